// ===== core/p2osm_params.svh
// Offsets, field positions and reset values of the pin 2 output control register and of the synchroniser.
// Included by the package and by the design modules; definitions only.
`ifndef P2OSM_PARAMS_SVH
`define P2OSM_PARAMS_SVH

`define P2OSM_ADDR_W 8
`define P2OSM_CTRL_OFFSET 8'h12
`define P2OSM_CTRL_RESET 8'h00
`define P2OSM_EN_BIT 0
`define P2OSM_VAL_BIT 1
`define P2OSM_SRC_LSB 2
`define P2OSM_SRC_MSB 4
`define P2OSM_SEL_LSB 5
`define P2OSM_SEL_MSB 7
`define P2OSM_SYNC_RESET 1'h0

`endif

// ===== core/p2osm_pkg.sv
// Types shared by the pin 2 output source multiplexer.
// Assumes p2osm_params.svh is on the include path.
`include "p2osm_params.svh"

package p2osm_pkg;

	typedef enum logic [2:0] {
		P2OSM_SRC_RX0 = 3'h0,
		P2OSM_SRC_RX1 = 3'h1,
		P2OSM_SRC_RX2 = 3'h2,
		P2OSM_SRC_RX3 = 3'h3,
		P2OSM_SRC_STATUS = 3'h4,
		P2OSM_SRC_RSVD = 3'h5,
		P2OSM_SRC_TX0 = 3'h6,
		P2OSM_SRC_TX1 = 3'h7
	} p2osm_src_t;

	typedef struct packed {
		logic [2:0] signal_select;
		p2osm_src_t source_select;
		logic local_value;
		logic drive_enable;
	} p2osm_ctrl_t;

	typedef struct packed {
		p2osm_ctrl_t ctrl;
		logic [7:0] rdata;
		logic pin_out;
		logic pin_oe;
	} p2osm_state_t;

	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] sync;
	} p2osm_sync_state_t;

endpackage : p2osm_pkg

// ===== core/p2osm_sync.sv
// Two flip-flop synchroniser for one level.
// Assumes the input may change at any time relative to clk.
`include "p2osm_params.svh"

module p2osm_sync
	import p2osm_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic d,
	output logic q
);

	logic stage1;
	logic stage2;

	// First stage is read only by the second stage
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stage1 <= `P2OSM_SYNC_RESET;
			stage2 <= `P2OSM_SYNC_RESET;
		end else begin
			stage1 <= d;
			stage2 <= stage1;
		end
	end

	assign q = stage2;

endmodule : p2osm_sync

// ===== core/p2osm_top.sv
// Pin 2 output source multiplexer: control register and routed pin driver.
// Assumes the routed receive, status and transmit signals come from other clock
// domains or pins, so each is synchronised before use.
`include "p2osm_params.svh"

module p2osm_top
	import p2osm_pkg::*;
#(
	parameter int NUM_RX = 4,
	parameter int NUM_TX = 2
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic [NUM_RX-1:0] rx_gpio0,
	input wire logic [NUM_RX-1:0] rx_gpio1,
	input wire logic [NUM_RX-1:0] rx_gpio2,
	input wire logic [NUM_RX-1:0] rx_gpio3,
	input wire logic [NUM_RX-1:0] rx_lock,
	input wire logic [NUM_RX-1:0] rx_pass,
	input wire logic [NUM_RX-1:0] rx_frame_valid,
	input wire logic [NUM_RX-1:0] rx_line_valid,
	input wire logic [NUM_RX-1:0] rx_port_enable,
	input wire logic frame_sync_pulse,
	input wire logic [NUM_TX-1:0] tx_pass_and,
	input wire logic [NUM_TX-1:0] tx_pass_or,
	input wire logic [NUM_TX-1:0] tx_frame_valid,
	input wire logic [NUM_TX-1:0] tx_line_valid,
	input wire logic [NUM_TX-1:0] tx_synchronized,
	input wire logic [NUM_TX-1:0] tx_interrupt,
	output logic pin_out,
	output logic pin_oe
);

	localparam int RX_W = 9 * NUM_RX;
	localparam int TX_W = 6 * NUM_TX;
	localparam int IN_W = RX_W + 1 + TX_W;

	logic [IN_W-1:0] raw_in;
	logic [IN_W-1:0] syn_in;

	assign raw_in = {tx_interrupt, tx_synchronized, tx_line_valid, tx_frame_valid, tx_pass_or, tx_pass_and,
		frame_sync_pulse, rx_port_enable, rx_line_valid, rx_frame_valid, rx_pass, rx_lock,
		rx_gpio3, rx_gpio2, rx_gpio1, rx_gpio0};

	// Every routed signal is asynchronous to clk, so all pass two flip-flops
	genvar gi;
	generate
		for (gi = 0; gi < IN_W; gi++) begin : g_sync
			p2osm_sync u_sync (
				.clk(clk),
				.nrst(nrst),
				.d(raw_in[gi]),
				.q(syn_in[gi])
			);
		end
	endgenerate

	logic [NUM_RX-1:0] s_gpio0, s_gpio1, s_gpio2, s_gpio3;
	logic [NUM_RX-1:0] s_lock, s_pass, s_fv, s_lv, s_en;
	logic s_fsync;
	logic [NUM_TX-1:0] s_tand, s_tor, s_tfv, s_tlv, s_tsync, s_tint;

	assign s_gpio0 = syn_in[0*NUM_RX +: NUM_RX];
	assign s_gpio1 = syn_in[1*NUM_RX +: NUM_RX];
	assign s_gpio2 = syn_in[2*NUM_RX +: NUM_RX];
	assign s_gpio3 = syn_in[3*NUM_RX +: NUM_RX];
	assign s_lock = syn_in[4*NUM_RX +: NUM_RX];
	assign s_pass = syn_in[5*NUM_RX +: NUM_RX];
	assign s_fv = syn_in[6*NUM_RX +: NUM_RX];
	assign s_lv = syn_in[7*NUM_RX +: NUM_RX];
	assign s_en = syn_in[8*NUM_RX +: NUM_RX];
	assign s_fsync = syn_in[RX_W];
	assign s_tand = syn_in[RX_W + 1 + 0*NUM_TX +: NUM_TX];
	assign s_tor = syn_in[RX_W + 1 + 1*NUM_TX +: NUM_TX];
	assign s_tfv = syn_in[RX_W + 1 + 2*NUM_TX +: NUM_TX];
	assign s_tlv = syn_in[RX_W + 1 + 3*NUM_TX +: NUM_TX];
	assign s_tsync = syn_in[RX_W + 1 + 4*NUM_TX +: NUM_TX];
	assign s_tint = syn_in[RX_W + 1 + 5*NUM_TX +: NUM_TX];

	// Signal for one receive port and one signal code
	function automatic logic rx_pick(input logic [2:0] sel, input int p,
		input logic [NUM_RX-1:0] g0, input logic [NUM_RX-1:0] g1,
		input logic [NUM_RX-1:0] g2, input logic [NUM_RX-1:0] g3,
		input logic [NUM_RX-1:0] lk, input logic [NUM_RX-1:0] ps,
		input logic [NUM_RX-1:0] fv, input logic [NUM_RX-1:0] lv);
		logic r;
		r = 1'h0;
		unique case (sel)
			3'h0: r = g0[p];
			3'h1: r = g1[p];
			3'h2: r = g2[p];
			3'h3: r = g3[p];
			3'h4: r = lk[p];
			3'h5: r = ps[p];
			3'h6: r = fv[p];
			3'h7: r = lv[p];
		endcase
		return r;
	endfunction : rx_pick

	// Signal for one transmit port and one signal code
	function automatic logic tx_pick(input logic [2:0] sel, input int p,
		input logic [NUM_TX-1:0] ta, input logic [NUM_TX-1:0] to,
		input logic [NUM_TX-1:0] tf, input logic [NUM_TX-1:0] tl,
		input logic [NUM_TX-1:0] ts, input logic [NUM_TX-1:0] ti);
		logic r;
		r = 1'h0;
		unique case (sel)
			3'h0: r = ta[p];
			3'h1: r = to[p];
			3'h2: r = tf[p];
			3'h3: r = tl[p];
			3'h4: r = ts[p];
			3'h5: r = ti[p];
			3'h6: r = 1'h0;
			3'h7: r = 1'h0;
		endcase
		return r;
	endfunction : tx_pick

	p2osm_state_t cur;
	p2osm_state_t next_cur;
	logic route_bit;
	logic lock_or;
	logic lock_and;
	logic pass_and;

	// Disabled ports do not take part; with none enabled the AND terms read 0
	assign lock_or = |(s_lock & s_en);
	assign lock_and = (|s_en) & (&(s_lock | ~s_en));
	assign pass_and = (|s_en) & (&(s_pass | ~s_en));

	always_comb begin
		route_bit = 1'h0;
		unique case (cur.ctrl.source_select)
			P2OSM_SRC_RX0, P2OSM_SRC_RX1, P2OSM_SRC_RX2, P2OSM_SRC_RX3: begin
				route_bit = rx_pick(cur.ctrl.signal_select, int'(cur.ctrl.source_select[1:0]),
					s_gpio0, s_gpio1, s_gpio2, s_gpio3, s_lock, s_pass, s_fv, s_lv);
			end
			P2OSM_SRC_STATUS: begin
				unique case (cur.ctrl.signal_select)
					3'h0: route_bit = cur.ctrl.local_value;
					3'h1: route_bit = lock_or;
					3'h2: route_bit = lock_and;
					3'h3: route_bit = pass_and;
					3'h4: route_bit = s_fsync;
					default: route_bit = 1'h0;
				endcase
			end
			// Reserved source drives a quiet low rather than anything stale
			P2OSM_SRC_RSVD: route_bit = 1'h0;
			P2OSM_SRC_TX0: route_bit = tx_pick(cur.ctrl.signal_select, 0,
				s_tand, s_tor, s_tfv, s_tlv, s_tsync, s_tint);
			P2OSM_SRC_TX1: route_bit = tx_pick(cur.ctrl.signal_select, NUM_TX - 1,
				s_tand, s_tor, s_tfv, s_tlv, s_tsync, s_tint);
		endcase
	end

	always_comb begin
		next_cur = cur;
		if (wr && addr == `P2OSM_CTRL_OFFSET) begin
			next_cur.ctrl = p2osm_ctrl_t'(wdata);
		end
		// Unmapped reads return zero; rdata holds only the cycle after rd
		next_cur.rdata = 8'h00;
		if (rd && addr == `P2OSM_CTRL_OFFSET) begin
			next_cur.rdata = cur.ctrl;
		end
		// One flop stage after selection keeps the pin glitch free
		next_cur.pin_out = route_bit;
		next_cur.pin_oe = cur.ctrl.drive_enable;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cur.ctrl <= p2osm_ctrl_t'(`P2OSM_CTRL_RESET);
			cur.rdata <= 8'h00;
			cur.pin_out <= 1'h0;
			cur.pin_oe <= 1'h0;
		end else begin
			cur <= next_cur;
		end
	end

	assign rdata = cur.rdata;
	assign pin_out = cur.pin_out;
	assign pin_oe = cur.pin_oe;

endmodule : p2osm_top

// ===== testbench/p2osm_board.sv
// Board logic on pin 2: a receiver with a pull-down.
// Assumes pin_oe high means the block drives the pin.
module p2osm_board (
	input wire logic pin_out,
	input wire logic pin_oe,
	output logic level
);
	timeunit 1ns;
	timeprecision 1ns;
	// Released wire falls to the pull-down, never keeps the last value
	assign level = pin_oe ? pin_out : 1'b0;
endmodule : p2osm_board

// ===== testbench/p2osm_monitor.sv
// Port checker for the pin 2 output multiplexer.
// Bound to p2osm_top; tracks the control register from the write strobes.
`include "p2osm_params.svh"
module p2osm_monitor
	import p2osm_pkg::*;
#(
	parameter int NUM_RX = 4,
	parameter int NUM_TX = 2
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic [NUM_RX-1:0] rx_lock,
	input wire logic [NUM_TX-1:0] tx_interrupt,
	input wire logic pin_out,
	input wire logic pin_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic [7:0] ctl;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) ctl <= `P2OSM_CTRL_RESET;
		else if (wr && addr == `P2OSM_CTRL_OFFSET) ctl <= wdata;
	end
	sequence lock0_held;
		(ctl[7:2] == 6'h20 && rx_lock[0]) [*5];
	endsequence
	oe_track_a: assert property ($stable(ctl) [*2] |-> pin_oe == ctl[0])
		else $error("pin_oe differs from enable bit");
	rd_back_a: assert property (rd && addr == `P2OSM_CTRL_OFFSET |=> rdata == $past(ctl))
		else $error("read data differs from control");
	rd_zero_a: assert property (!(rd && addr == `P2OSM_CTRL_OFFSET) |=> rdata == 8'h00)
		else $error("read data not zero");
	local_val_a: assert property ((ctl[7:2] == 6'h04 && $stable(ctl)) [*3] |-> pin_out == ctl[1])
		else $error("local value not routed");
	rsvd_src_a: assert property ((ctl[4:2] == 3'h5) [*3] |-> !pin_out)
		else $error("reserved source not low");
	st_rsvd_a: assert property ((ctl[4:2] == 3'h4 && ctl[7:5] > 3'h4) [*3] |-> !pin_out)
		else $error("reserved status code not low");
	rx_lock_a: assert property (lock0_held |-> pin_out)
		else $error("port 0 lock not routed");
	tx_int_a: assert property ((ctl[7:2] == 6'h2F && $stable(tx_interrupt)) [*5] |-> pin_out == tx_interrupt[1])
		else $error("port 1 interrupt not routed");
endmodule : p2osm_monitor

// ===== testbench/tb_top.sv
// Self-checking bench for the pin 2 output multiplexer.
// Assumes the board model and checker files are compiled first.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic fs = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [3:0] en = 4'h0;
	logic [7:0] rdata;
	logic pin_out, pin_oe, level;
	logic [3:0] rxs [8];
	logic [1:0] txs [6];
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	logic [21:0] tbl [15] = '{{8'h13, 12'h000, 2'b01}, {8'h11, 12'hFFF, 2'b10}, {8'h31, 12'h5AF, 2'b00},
		{8'h31, 12'h540, 2'b01}, {8'h51, 12'h5D0, 2'b01}, {8'h51, 12'h5B0, 2'b00}, {8'h71, 12'h5FD, 2'b01},
		{8'h71, 12'h5FE, 2'b00}, {8'h91, 12'h000, 2'b11}, {8'h91, 12'hFFF, 2'b00}, {8'hB1, 12'hFFF, 2'b10},
		{8'hD1, 12'hFFF, 2'b10}, {8'hF1, 12'hFFF, 2'b10}, {8'h95, 12'hFFF, 2'b10}, {8'h12, 12'h000, 2'b00}};
	p2osm_top #(.NUM_RX(4), .NUM_TX(2)) uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .rx_gpio0(rxs[0]), .rx_gpio1(rxs[1]), .rx_gpio2(rxs[2]), .rx_gpio3(rxs[3]),
		.rx_lock(rxs[4]), .rx_pass(rxs[5]), .rx_frame_valid(rxs[6]), .rx_line_valid(rxs[7]),
		.rx_port_enable(en), .frame_sync_pulse(fs), .tx_pass_and(txs[0]), .tx_pass_or(txs[1]),
		.tx_frame_valid(txs[2]), .tx_line_valid(txs[3]), .tx_synchronized(txs[4]), .tx_interrupt(txs[5]),
		.pin_out(pin_out), .pin_oe(pin_oe));
	p2osm_board board (.pin_out(pin_out), .pin_oe(pin_oe), .level(level));
	initial forever #50 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("rdata", e, rdata);
	endtask : rd_reg
	task automatic pin_t(input logic [7:0] c, input logic e);
		wr_reg(8'h12, c);
		repeat (5) @(posedge clk);
		#1;
		chk("pin", {7'h00, e}, {7'h00, level});
	endtask : pin_t
	task automatic t_regs;
		rd_reg(8'h12, 8'h00);
		chk("oe", 8'h00, {7'h00, pin_oe});
		wr_reg(8'h12, 8'hA5);
		rd_reg(8'h12, 8'hA5);
		wr_reg(8'h13, 8'hFF);
		rd_reg(8'h13, 8'h00);
		rd_reg(8'h12, 8'hA5);
		chk("oe", 8'h01, {7'h00, pin_oe});
		// Mid-run reset must drop the driver at once and clear the register
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		#1;
		chk("oe", 8'h00, {7'h00, pin_oe});
		@(posedge clk);
		nrst <= 1'b1;
		rd_reg(8'h12, 8'h00);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_rx;
		for (int p = 0; p < 4; p++) for (int s = 0; s < 8; s++) for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			// Other signals go high in the second pass to catch a wrong pick
			foreach (rxs[i]) rxs[i] <= (i == s) ? (k ? ~(4'h1 << p) : 4'h1 << p) : (k ? 4'hF : 4'h0);
			pin_t({3'(s), 3'(p), 2'b01}, k == 0);
		end
		foreach (rxs[i]) rxs[i] <= 4'h0;
		$display("t_rx done");
	endtask : t_rx
	task automatic t_tx;
		for (int p = 0; p < 2; p++) for (int s = 0; s < 8; s++) for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			foreach (txs[i]) txs[i] <= (i == s) ? (k ? ~(2'h1 << p) : 2'h1 << p) : ((k || s > 5) ? 2'h3 : 2'h0);
			pin_t({3'(s), 2'b11, 1'(p), 2'b01}, k == 0 && s < 6);
		end
		foreach (txs[i]) txs[i] <= 2'h0;
		$display("t_tx done");
	endtask : t_tx
	task automatic t_status;
		foreach (tbl[n]) begin
			@(posedge clk);
			{en, rxs[4], rxs[5], fs} <= tbl[n][13:1];
			pin_t(tbl[n][21:14], tbl[n][0]);
		end
		$display("t_status done");
	endtask : t_status
	task automatic end_sim;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim
	initial begin
		foreach (rxs[i]) rxs[i] = 4'h0;
		foreach (txs[i]) txs[i] = 2'h0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_rx();
		t_tx();
		t_status();
		end_sim();
	end
endmodule : tb_top
bind p2osm_top p2osm_monitor #(.NUM_RX(NUM_RX), .NUM_TX(NUM_TX)) mon (.clk(clk), .nrst(nrst), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_lock(rx_lock), .tx_interrupt(tx_interrupt),
	.pin_out(pin_out), .pin_oe(pin_oe));
